//--- src/setpoint_params.svh
`ifndef SETPOINT_PARAMS_SVH
`define SETPOINT_PARAMS_SVH

// apb byte offsets
`define OFF_STATUS 12'h000
`define OFF_CTRL 12'h004
`define OFF_SET_BASE 12'h010
`define OFF_SET_LAST 12'h030

// status and control word field positions
`define ST_PROG_BIT 0
`define ST_PERMIT_BIT 1
`define ST_OVSPD_BIT 2
`define ST_DISENG_BIT 3
`define ST_LOCK_BIT 4
`define ST_DIRTY_BIT 5
`define ST_ERR_BIT 6
`define ST_STATE_LSB 8
`define CTRL_CLR_DIRTY_BIT 0

// setting reset values, bcd coded
`define DEF_PRESS_UNIT 16'h0000
`define DEF_TEMP_UNIT 16'h0000
`define DEF_PUMP_RATIO 16'h0244
`define DEF_ENG_LIMIT 16'h0900
`define DEF_WARN_PUMP 16'h3650
`define DEF_DISENG_PUMP 16'h4500
`define DEF_OIL_WARN 16'h0212
`define DEF_OIL_SHUT 16'h0240
`define DEF_AUTO_ON 16'h0000

// engine speed treated as idle for lockout release
`define IDLE_RPM 16'h0320

// timing
`define CLK_HZ 10000000
`define HOLD_TIME_MS 3000
`define IDLE_TIME_MS 3000
`define HOLD_CYC_CALC (`HOLD_TIME_MS * (`CLK_HZ / 1000))
`define IDLE_CYC_CALC (`IDLE_TIME_MS * (`CLK_HZ / 1000))

// display glyphs
`define GLYPH_DASH 4'hA
`define GLYPH_ERR 4'hE
`define GLYPH_BLANK 4'hF

`endif

//--- src/setpoint_pkg.sv
`default_nettype none
package setpoint_pkg;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'b0_0001,
    ST_ACCESS = 5'b0_0010,
    ST_CODE = 5'b0_0100,
    ST_EDIT = 5'b0_1000,
    ST_EXIT = 5'b1_0000
  } prog_state_t;

  typedef enum logic [3:0] {
    SET_PRESS_UNIT = 4'h0,
    SET_TEMP_UNIT = 4'h1,
    SET_PUMP_RATIO = 4'h2,
    SET_ENG_LIMIT = 4'h3,
    SET_WARN_PUMP = 4'h4,
    SET_DISENG_PUMP = 4'h5,
    SET_OIL_WARN = 4'h6,
    SET_OIL_SHUT = 4'h7,
    SET_AUTO_ON = 4'h8,
    SET_NONE = 4'hF
  } setting_idx_t;

endpackage
`default_nettype wire

//--- src/compressor_setpoint_programmer.sv
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_params.svh"

module compressor_setpoint_programmer
  import setpoint_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `HOLD_CYC_CALC,
  parameter int unsigned IDLE_CYC = `IDLE_CYC_CALC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_btn,
  input wire logic onoff_btn,
  input wire logic interlock_in,
  input wire logic pressure_low_in,
  input wire logic [15:0] engine_rpm,
  input wire logic compressor_on,
  output logic [15:0] disp_digits,
  output logic [3:0] disp_flash,
  output logic program_active,
  output logic engage_permit,
  output logic overspeed_warn,
  output logic disengage_req,
  output logic reengage_lockout
);

  localparam int NSET = 9;
  localparam logic [15:0] DEFAULTS [NSET] = '{
    `DEF_PRESS_UNIT, `DEF_TEMP_UNIT, `DEF_PUMP_RATIO, `DEF_ENG_LIMIT,
    `DEF_WARN_PUMP, `DEF_DISENG_PUMP, `DEF_OIL_WARN, `DEF_OIL_SHUT,
    `DEF_AUTO_ON};
  localparam logic [15:0] DASHES = {4{`GLYPH_DASH}};
  localparam logic [15:0] BLANKS = {4{`GLYPH_BLANK}};

  function automatic logic [31:0] bcd2bin(input logic [15:0] b);
    bcd2bin = 32'(b[15:12]) * 1000 + 32'(b[11:8]) * 100
            + 32'(b[7:4]) * 10 + 32'(b[3:0]);
  endfunction

  function automatic logic [3:0] digit_inc(input logic [3:0] d);
    digit_inc = (d >= 4'h9) ? 4'h0 : d + 4'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, level changes when stages 2 and 3 agree
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, level_reg, prev_reg;
  logic [3:0] level_next;
  assign pin_raw = {pressure_low_in, interlock_in, onoff_btn, mode_btn};

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_sync
      assign level_next[gp] = (sync2_reg[gp] == sync3_reg[gp]) ?
                              sync3_reg[gp] : level_reg[gp];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      level_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
      prev_reg <= level_reg;
    end
  end

  wire mode_l = level_reg[0];
  wire onoff_l = level_reg[1];
  wire ilk_l = level_reg[2];
  wire press_low_l = level_reg[3];
  wire mode_press = mode_l & ~prev_reg[0];
  wire onoff_press = onoff_l & ~prev_reg[1];
  wire ilk_fall = prev_reg[2] & ~ilk_l;
  wire both_held = mode_l & onoff_l;
  // a press counts alone only; stops the exit gesture editing a digit
  wire mode_act = mode_press & ~onoff_l;
  wire onoff_act = onoff_press & ~mode_l;

  //////////////////////////////////////////////////////////////////////////
  // hold and inactivity counters
  prog_state_t state_reg, state_next;
  logic [31:0] hold_cnt_reg, hold_cnt_next;
  logic [31:0] idle_cnt_reg, idle_cnt_next;
  wire hold_cond = (state_reg == ST_NORMAL) ? (mode_l & ~onoff_l)
                                            : both_held;
  wire hold_done = hold_cond && (hold_cnt_reg >= HOLD_CYC - 1);
  wire idle_run = (state_reg == ST_ACCESS) || (state_reg == ST_CODE);
  wire idle_done = idle_run && (idle_cnt_reg >= IDLE_CYC - 1);

  assign hold_cnt_next = !hold_cond ? 32'h0000_0000 :
                         hold_done ? hold_cnt_reg : hold_cnt_reg + 32'd1;
  // counter held clear outside access and code entry, so edit never times out
  assign idle_cnt_next = (!idle_run || mode_press || onoff_press) ?
                         32'h0000_0000 : idle_cnt_reg + 32'd1;

  //////////////////////////////////////////////////////////////////////////
  // code entry and edit sequencing
  logic [3:0] dig_reg [3];
  logic [3:0] dig_next [3];
  logic [1:0] cur_reg, cur_next;
  logic [1:0] ecur_reg, ecur_next;
  logic err_reg, err_next;
  setting_idx_t sel_reg, sel_next, code_idx;
  logic edit_we;
  logic [15:0] set_reg [NSET];
  logic [15:0] edit_val;
  logic [15:0] sel_val;
  logic [3:0] opt_cnt;

  always_comb begin
    code_idx = SET_NONE;
    if (dig_reg[0] == 4'h3 && dig_reg[1] == 4'h1) begin
      case (dig_reg[2])
        4'h0: code_idx = SET_PRESS_UNIT;
        4'h1: code_idx = SET_TEMP_UNIT;
        4'h2: code_idx = SET_PUMP_RATIO;
        4'h3: code_idx = SET_ENG_LIMIT;
        4'h4: code_idx = SET_WARN_PUMP;
        4'h5: code_idx = SET_DISENG_PUMP;
        4'h6: code_idx = SET_OIL_WARN;
        4'h7: code_idx = SET_OIL_SHUT;
        default: code_idx = SET_NONE;
      endcase
    end else if (dig_reg[0] == 4'h3 && dig_reg[1] == 4'h2 &&
                 dig_reg[2] == 4'h1) begin
      code_idx = SET_AUTO_ON;
    end
  end

  assign sel_val = (sel_reg == SET_NONE) ? 16'h0000 : set_reg[sel_reg];
  assign opt_cnt = (sel_reg == SET_PRESS_UNIT) ? 4'h3 :
                   (sel_reg == SET_TEMP_UNIT || sel_reg == SET_AUTO_ON) ?
                   4'h2 : 4'h0;

  always_comb begin
    edit_val = sel_val;
    if (opt_cnt != 4'h0) begin
      edit_val = (sel_val[3:0] + 4'h1 >= opt_cnt) ? 16'h0000 :
                 {12'h000, sel_val[3:0] + 4'h1};
    end else begin
      case (ecur_reg)
        2'd0: edit_val[15:12] = digit_inc(sel_val[15:12]);
        2'd1: edit_val[11:8] = digit_inc(sel_val[11:8]);
        2'd2: edit_val[7:4] = digit_inc(sel_val[7:4]);
        default: edit_val[3:0] = digit_inc(sel_val[3:0]);
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    dig_next = dig_reg;
    cur_next = cur_reg;
    ecur_next = ecur_reg;
    err_next = err_reg;
    sel_next = sel_reg;
    edit_we = 1'b0;
    case (state_reg)
      ST_NORMAL: begin
        if (hold_done) begin
          state_next = ST_ACCESS;
          err_next = 1'b0;
        end
      end
      ST_ACCESS: begin
        if (idle_done) begin
          state_next = ST_NORMAL;
        end else if (onoff_act) begin
          state_next = ST_CODE;
          dig_next = '{4'h1, 4'h0, 4'h0};
          cur_next = 2'd0;
          err_next = 1'b0;
        end
      end
      ST_CODE: begin
        if (idle_done) begin
          state_next = ST_NORMAL;
        end else if (onoff_act) begin
          if (cur_reg == 2'd0) begin
            dig_next[0] = digit_inc(dig_reg[0]);
          end else if (cur_reg == 2'd1) begin
            cur_next = 2'd2;
          end else begin
            dig_next[2] = digit_inc(dig_reg[2]);
          end
        end else if (mode_act) begin
          if (cur_reg == 2'd0) begin
            cur_next = 2'd1;
          end else if (cur_reg == 2'd1) begin
            dig_next[1] = digit_inc(dig_reg[1]);
          end else if (code_idx != SET_NONE) begin
            state_next = ST_EDIT;
            sel_next = code_idx;
            ecur_next = 2'd0;
          end else begin
            state_next = ST_ACCESS;
            err_next = 1'b1;
          end
        end
      end
      ST_EDIT: begin
        if (hold_done) begin
          state_next = ST_EXIT;
        end else if (mode_act && opt_cnt == 4'h0) begin
          ecur_next = ecur_reg + 2'd1;
        end else if (onoff_act) begin
          edit_we = 1'b1;
        end
      end
      ST_EXIT: begin
        if (!mode_l && !onoff_l) begin
          state_next = ST_ACCESS;
          err_next = 1'b0;
        end
      end
      default: state_next = ST_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_NORMAL;
      dig_reg <= '{4'h1, 4'h0, 4'h0};
      cur_reg <= 2'd0;
      ecur_reg <= 2'd0;
      err_reg <= 1'b0;
      sel_reg <= SET_NONE;
      hold_cnt_reg <= 32'h0000_0000;
      idle_cnt_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      dig_reg <= dig_next;
      cur_reg <= cur_next;
      ecur_reg <= ecur_next;
      err_reg <= err_next;
      sel_reg <= sel_next;
      hold_cnt_reg <= hold_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_status = (paddr == `OFF_STATUS);
  wire hit_ctrl = (paddr == `OFF_CTRL);
  wire in_set = (paddr >= `OFF_SET_BASE) && (paddr <= `OFF_SET_LAST) &&
                (paddr[1:0] == 2'b00);
  wire [3:0] set_sel = 4'((paddr - `OFF_SET_BASE) >> 2);
  wire mapped = hit_status | hit_ctrl | in_set;
  logic dirty_reg;

  wire [31:0] status_word =
    (32'(state_reg) << `ST_STATE_LSB) |
    (32'(err_reg) << `ST_ERR_BIT) | (32'(dirty_reg) << `ST_DIRTY_BIT) |
    (32'(reengage_lockout) << `ST_LOCK_BIT) |
    (32'(disengage_req) << `ST_DISENG_BIT) |
    (32'(overspeed_warn) << `ST_OVSPD_BIT) |
    (32'(engage_permit) << `ST_PERMIT_BIT) |
    (32'(program_active) << `ST_PROG_BIT);
  wire [31:0] rd_word = hit_status ? status_word :
                        hit_ctrl ? {31'h0000_0000, dirty_reg} :
                        in_set ? {16'h0000, set_reg[set_sel]} :
                        32'h0000_0000;
  wire clr_dirty = access & pwrite & hit_ctrl &
                   pwdata[`CTRL_CLR_DIRTY_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      dirty_reg <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= setup & ~mapped;
      // edit sets, software clears; set wins on a tie
      dirty_reg <= edit_we | (dirty_reg & ~clr_dirty);
    end
  end

  // software restores saved values here after power-up; reset loads defaults
  genvar gs;
  generate
    for (gs = 0; gs < NSET; gs++) begin : g_set
      wire sw_we = access & pwrite & in_set & (set_sel == 4'(gs));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          set_reg[gs] <= DEFAULTS[gs];
        end else if (edit_we && sel_reg == setting_idx_t'(gs)) begin
          set_reg[gs] <= edit_val;
        end else if (sw_we) begin
          set_reg[gs] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // display
  logic [15:0] disp_next;
  logic [3:0] flash_next;
  always_comb begin
    disp_next = BLANKS;
    flash_next = 4'h0;
    case (state_reg)
      ST_NORMAL: disp_next = hold_cond ? DASHES : BLANKS;
      ST_ACCESS: begin
        disp_next = err_reg ? {`GLYPH_ERR, dig_reg[0], dig_reg[1],
                               dig_reg[2]} : DASHES;
      end
      ST_CODE: begin
        disp_next = {`GLYPH_BLANK, dig_reg[0], dig_reg[1], dig_reg[2]};
        flash_next = 4'b0100 >> cur_reg;
      end
      ST_EDIT: begin
        disp_next = both_held ? DASHES : sel_val;
        flash_next = both_held ? 4'h0 :
                     (opt_cnt != 4'h0) ? 4'hF : 4'b1000 >> ecur_reg;
      end
      ST_EXIT: disp_next = DASHES;
      default: disp_next = BLANKS;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // engagement supervision from the stored settings
  wire [31:0] rpm32 = 32'(engine_rpm);
  wire [31:0] ratio = bcd2bin(set_reg[SET_PUMP_RATIO]);
  // ratio is hundredths: compare rpm*ratio with limit*100, no divider
  wire ovspd = rpm32 * ratio > bcd2bin(set_reg[SET_WARN_PUMP]) * 100;
  wire diseng = rpm32 * ratio > bcd2bin(set_reg[SET_DISENG_PUMP]) * 100;
  wire rpm_ok = rpm32 <= bcd2bin(set_reg[SET_ENG_LIMIT]);
  wire lock_set = ilk_fall & compressor_on;
  wire lock_clr = press_low_l & (engine_rpm <= `IDLE_RPM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_digits <= BLANKS;
      disp_flash <= 4'h0;
      program_active <= 1'b0;
      engage_permit <= 1'b0;
      overspeed_warn <= 1'b0;
      disengage_req <= 1'b0;
      reengage_lockout <= 1'b0;
    end else begin
      disp_digits <= disp_next;
      disp_flash <= flash_next;
      program_active <= (state_reg != ST_NORMAL);
      engage_permit <= ilk_l & rpm_ok & ~reengage_lockout &
                       ~lock_set;
      overspeed_warn <= ovspd;
      disengage_req <= diseng | reengage_lockout;
      reengage_lockout <= lock_set | (reengage_lockout & ~lock_clr);
    end
  end

endmodule
`default_nettype wire

//--- tb/setpoint_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module setpoint_monitor #(
  parameter int unsigned IDLE_CYC = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mode_btn,
  input wire logic onoff_btn,
  input wire logic interlock_in,
  input wire logic [15:0] engine_rpm,
  input wire logic compressor_on,
  input wire logic [15:0] disp_digits,
  input wire logic [3:0] disp_flash,
  input wire logic program_active,
  input wire logic engage_permit,
  input wire logic overspeed_warn,
  input wire logic disengage_req,
  input wire logic reengage_lockout
);
  logic [31:0] idle_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // counts idle dashes; slack below covers sync and display lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= '0;
    end else if (mode_btn || onoff_btn || !program_active ||
                 disp_digits != 16'hAAAA) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end
////////////////////////////////////////
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_zero:
    assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error reply carries data");
  a_permit_rpm:
    assert property (engage_permit |-> $past(engine_rpm) <= 16'h0384 ||
                     $past(engine_rpm, 2) <= 16'h0384)
    else $error("permit above speed limit");
  a_ovspd_rpm:
    assert property (overspeed_warn |-> $past(engine_rpm) > 16'h05D7 ||
                     $past(engine_rpm, 2) > 16'h05D7)
    else $error("overspeed below threshold");
  a_lock_set:
    assert property ($fell(interlock_in) && compressor_on |->
                     ##[1:6] reengage_lockout)
    else $error("no lockout on interlock drop");
  a_lock_hold:
    assert property (reengage_lockout && $past(reengage_lockout) |->
                     disengage_req && !engage_permit)
    else $error("lockout not enforced");
  a_normal_noflash:
    assert property (!program_active && !$past(program_active) |->
                     disp_flash == 4'h0)
    else $error("flashing in normal operation");
  a_flash_cursor:
    assert property (program_active |->
                     $onehot0(disp_flash) || disp_flash == 4'hF)
    else $error("bad flash pattern");
  a_dash_timeout:
    assert property (idle_cnt <= IDLE_CYC + 10)
    else $error("idle dashes never time out");
  c_third: cover property (program_active && disp_flash == 4'b0001);
  c_lock: cover property (reengage_lockout);
  c_ovspd: cover property (overspeed_warn && disengage_req);
endmodule
bind compressor_setpoint_programmer setpoint_monitor #(
  .IDLE_CYC(IDLE_CYC)
) setpoint_monitor_i (.pclk, .presetn, .prdata, .pready, .pslverr,
  .mode_btn, .onoff_btn, .interlock_in, .engine_rpm, .compressor_on,
  .disp_digits, .disp_flash, .program_active, .engage_permit,
  .overspeed_warn, .disengage_req, .reengage_lockout);
`default_nettype wire

//--- tb/operator_panel.sv
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
  input wire logic pclk,
  output logic mode_btn,
  output logic onoff_btn,
  output logic interlock_in,
  output logic pressure_low_in
);
  initial begin
    mode_btn = 1'b0;
    onoff_btn = 1'b0;
    interlock_in = 1'b1;
    pressure_low_in = 1'b0;
  end
  // a held thumb: levels stay until told otherwise
  task automatic set_btn(input logic m, input logic o);
    mode_btn <= m;
    onoff_btn <= o;
    @(posedge pclk);
  endtask
  // long enough for the input sync, then a clear gap
  task automatic tap(input logic m);
    if (m) begin
      mode_btn <= 1'b1;
    end else begin
      onoff_btn <= 1'b1;
    end
    repeat (4) @(posedge pclk);
    mode_btn <= 1'b0;
    onoff_btn <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic lines(input logic il, input logic pl);
    interlock_in <= il;
    pressure_low_in <= pl;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- tb/compressor_setpoint_programmer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module compressor_setpoint_programmer_tb;
  localparam int unsigned HC = 20;
  localparam int unsigned IC = 40;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [15:0] DEF_TAB [9] = '{16'h0000, 16'h0000, 16'h0244,
    16'h0900, 16'h3650, 16'h4500, 16'h0212, 16'h0240, 16'h0000};
  localparam logic [15:0] RPM_TAB [6] = '{16'h0384, 16'h0385, 16'h05D7,
    16'h05D8, 16'h0734, 16'h0735};
  localparam logic [2:0] SPD_TAB [6] = '{3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h3};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, compressor_on;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [15:0] engine_rpm;
  logic [31:0] prdata;
  logic [15:0] disp_digits;
  logic [3:0] disp_flash;
  logic pready, pslverr, mode_btn, onoff_btn, interlock_in, pressure_low_in;
  logic program_active, engage_permit, overspeed_warn, disengage_req;
  logic reengage_lockout;
  wire [2:0] spd = {engage_permit, overspeed_warn, disengage_req};
  int errors = 0;
  int checks = 0;
  always #50 pclk = ~pclk;
  compressor_setpoint_programmer #(.HOLD_CYC(HC), .IDLE_CYC(IC))
    compressor_setpoint_programmer_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_btn,
    .onoff_btn, .interlock_in, .pressure_low_in, .engine_rpm,
    .compressor_on, .disp_digits, .disp_flash, .program_active,
    .engage_permit, .overspeed_warn, .disengage_req, .reengage_lockout);
  operator_panel operator_panel_i (.pclk, .mode_btn, .onoff_btn,
    .interlock_in, .pressure_low_in);
////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait count assumed; only the bench timeout ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never reassigns in this step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, ZERO, q, e);
    chk(q, x, "read");
    chk(32'(e), 32'(xe), "read err");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(32'(e), 32'(xe), "write err");
  endtask
  task automatic enter;
    operator_panel_i.set_btn(1'b1, 1'b0);
    repeat (HC + 10) @(posedge pclk);
    chk(32'({program_active, disp_digits}), 32'h0001_AAAA, "enter");
    operator_panel_i.set_btn(1'b0, 1'b0);
  endtask
  task automatic code(input logic [3:0] d1, input logic [3:0] d2,
                      input logic [3:0] d3);
    operator_panel_i.tap(1'b0);
    chk(32'({disp_digits, disp_flash}), 32'h000F_1004, "first");
    repeat ((int'(d1) + 9) % 10) operator_panel_i.tap(1'b0);
    operator_panel_i.tap(1'b1);
    chk(32'(disp_flash), 32'h0000_0002, "second");
    repeat (d2) operator_panel_i.tap(1'b1);
    operator_panel_i.tap(1'b0);
    chk(32'(disp_flash), ONE, "third");
    repeat (d3) operator_panel_i.tap(1'b0);
    chk(32'(disp_digits), 32'({4'hF, d1, d2, d3}), "digits");
    operator_panel_i.tap(1'b1);
  endtask
  task automatic leave;
    operator_panel_i.set_btn(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    operator_panel_i.set_btn(1'b1, 1'b1);
    repeat (HC + 10) @(posedge pclk);
    chk(32'(disp_digits), 32'h0000_AAAA, "exit dashes");
    operator_panel_i.set_btn(1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    chk(32'({program_active, disp_digits}), 32'h0001_AAAA, "exit");
  endtask
  task automatic t_defaults;
    logic [11:0] a;
    a = 12'h010;
    for (int i = 0; i < 9; i++) begin
      rd(a, 32'(DEF_TAB[i]), 1'b0);
      a += 12'h004;
    end
    rd(12'h100, ZERO, 1'b1);
    wr(12'h100, 32'h0000_1234, 1'b1);
    rd(12'h000, 32'h0000_0102, 1'b0);
  endtask
  task automatic t_timeout;
    enter();
    repeat (20) @(posedge pclk);
    chk(32'(program_active), ONE, "early");
    repeat (IC) @(posedge pclk);
    chk(32'(program_active), ZERO, "timeout");
    enter();
    code(4'h0, 4'h0, 4'h5);
    chk(32'(disp_digits), 32'h0000_E005, "bad code");
    repeat (IC + 15) @(posedge pclk);
    chk(32'(program_active), ZERO, "bad timeout");
  endtask
  task automatic t_edit;
    enter();
    code(4'h3, 4'h1, 4'h6);
    chk(32'(disp_digits), 32'h0000_0212, "value");
    repeat (2 * IC) @(posedge pclk);
    chk(32'(program_active), ONE, "held");
    operator_panel_i.tap(1'b0);
    chk(32'(disp_digits), 32'h0000_1212, "step");
    rd(12'h004, ONE, 1'b0);
    repeat (9) operator_panel_i.tap(1'b0);
    chk(32'(disp_digits), 32'h0000_0212, "wrap");
    rd(12'h028, 32'h0000_0212, 1'b0);
    leave();
    code(4'h3, 4'h2, 4'h1);
    operator_panel_i.tap(1'b0);
    rd(12'h030, ONE, 1'b0);
    operator_panel_i.tap(1'b0);
    rd(12'h030, ZERO, 1'b0);
    leave();
    code(4'h3, 4'h1, 4'h0);
    for (int i = 1; i < 4; i++) begin
      operator_panel_i.tap(1'b0);
      rd(12'h010, 32'(i % 3), 1'b0);
    end
    leave();
    repeat (IC + 15) @(posedge pclk);
    chk(32'(program_active), ZERO, "exit timeout");
    wr(12'h004, ONE, 1'b0);
    rd(12'h004, ZERO, 1'b0);
    wr(12'h028, 32'h0000_0199, 1'b0);
    rd(12'h028, 32'h0000_0199, 1'b0);
  endtask
  task automatic t_speed;
    for (int i = 0; i < 6; i++) begin
      engine_rpm <= RPM_TAB[i];
      repeat (4) @(posedge pclk);
      chk(32'(spd), 32'(SPD_TAB[i]), "speed");
    end
    compressor_on <= 1'b1;
    engine_rpm <= 16'h03E8;
    operator_panel_i.lines(1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    chk(32'({reengage_lockout, spd}), 32'h0000_0009, "lock");
    operator_panel_i.lines(1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    chk(32'(reengage_lockout), ONE, "lock kept");
    engine_rpm <= 16'h0320;
    repeat (8) @(posedge pclk);
    chk(32'({reengage_lockout, engage_permit}), ONE, "unlock");
  endtask
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= ZERO;
    engine_rpm <= 16'h0000;
    compressor_on <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults();
    t_timeout();
    t_edit();
    t_speed();
    tally_and_finish();
  end
  initial begin
    repeat (10000) @(posedge pclk);
    errors++;
    $display("[FAIL] %0t timeout", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
